// [logic/smm_cmd_map.sv]
// internal address to external command word mapping
`timescale 1ns/100ps
`include "smm_regs.svh"
module smm_cmd_map
    import smm_pkg::*;
(
    input wire logic [31:0] i_addr,
    input wire logic i_width16,
    output logic [12:0] o_word
);
    // narrow bus shifts the mapping down one bit
    always_comb
    begin
        if (i_width16)
            o_word = i_addr[21:9];
        else
            o_word = i_addr[22:10];
    end
endmodule

// [logic/smm_domain_cfg.sv]
// one domain device configuration register
`timescale 1ns/100ps
`include "smm_regs.svh"
module smm_domain_cfg
    import smm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic [3:0] o_cfg
);
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            o_cfg <= 4'(`SMM_DCFG_RESET);
        else if (i_wr)
            o_cfg <= i_wdata[3:0];
    end
endmodule

// [logic/smm_pkg.sv]
// types shared by the mode setup block
package smm_pkg;
    typedef enum logic [3:0]
    {
        SMM_CMD_NOP,
        SMM_CMD_PRECHARGE_ALL,
        SMM_CMD_LOAD_MODE,
        SMM_CMD_AUTO_REFRESH,
        SMM_CMD_SELF_REFRESH,
        SMM_CMD_SELF_REFRESH_EXIT,
        SMM_CMD_READ,
        SMM_CMD_WRITE,
        SMM_CMD_FLASH_REG
    } smm_cmd_t;
    typedef enum logic [1:0]
    {
        SMM_TYPE_SDRAM,
        SMM_TYPE_SYNC_ROM,
        SMM_TYPE_SYNC_FLASH
    } smm_dev_t;
endpackage

// [logic/smm_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef SMM_REGS_SVH
`define SMM_REGS_SVH
`define SMM_GLOBAL_CFG_OFS 32'h0000_0000
`define SMM_DOMAIN_CFG0_OFS 32'h0000_0010
`define SMM_STANDBY_OFS 32'h0000_0020
`define SMM_STATUS_OFS 32'h0000_0024
`define SMM_CMD_WORD_OFS 32'h0000_0028
`define SMM_GCFG_INIT_BIT 0
`define SMM_GCFG_MODE_SET_BIT 1
`define SMM_GCFG_LOAD_CFG_BIT 2
`define SMM_DCFG_WIDTH16_BIT 0
`define SMM_DCFG_SINGLE_WR_BIT 1
`define SMM_DCFG_TYPE_LSB 2
`define SMM_GCFG_RESET 32'h0000_0001
`define SMM_DCFG_RESET 32'h0000_0000
`define SMM_WAKE_NOP_COUNT 4'hA
`define SMM_STABLE_TIME_NS 1000
`define SMM_CLK_PERIOD_NS 50
`define SMM_STABLE_CYCLES ((`SMM_STABLE_TIME_NS+`SMM_CLK_PERIOD_NS-1)/`SMM_CLK_PERIOD_NS)
`define SMM_REFRESH_PERIOD_CYCLES 8'd156
`endif

// [logic/smm_top.sv]
// synchronous memory mode setup and self refresh sequencer
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "smm_regs.svh"
module smm_top
    import smm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_mem_req,
    input wire logic i_mem_write,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata,
    input wire logic [31:0] i_mem_dq_in,
    input wire logic i_standby_req,
    output logic o_standby_ack,
    output logic [12:0] o_mem_addr,
    output logic [31:0] o_mem_dq_out,
    output logic o_mem_dq_oen,
    output logic [3:0] o_mem_domain_sel,
    output smm_cmd_t o_mem_cmd,
    output logic o_memory_clock_enable_out
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [2:0] global_memory_config;
    logic [3:0] domain_cfg [4];
    logic [3:0] dcfg_wr;
    logic apb_access;
    logic apb_hit;
    logic [12:0] last_cmd_word;
    logic standby_ack_q;
    logic init_bit;
    logic mode_set_enable;
    logic load_config_enable;
    logic setup_active;

    assign apb_access = i_psel && i_penable;
    assign o_pready = 1'b1;
    assign init_bit = global_memory_config[`SMM_GCFG_INIT_BIT];
    assign mode_set_enable = global_memory_config[`SMM_GCFG_MODE_SET_BIT];
    assign load_config_enable = global_memory_config[`SMM_GCFG_LOAD_CFG_BIT];
    assign setup_active = init_bit || mode_set_enable
        || load_config_enable;

    always_comb
    begin
        apb_hit = 1'b1;
        dcfg_wr = 4'h0;
        o_prdata = 32'h0000_0000;
        unique case (i_paddr)
            `SMM_GLOBAL_CFG_OFS:
                o_prdata = {29'h0, global_memory_config};
            `SMM_DOMAIN_CFG0_OFS:
            begin
                o_prdata = {28'h0, domain_cfg[0]};
                dcfg_wr[0] = 1'b1;
            end
            `SMM_DOMAIN_CFG0_OFS + 32'h4:
            begin
                o_prdata = {28'h0, domain_cfg[1]};
                dcfg_wr[1] = 1'b1;
            end
            `SMM_DOMAIN_CFG0_OFS + 32'h8:
            begin
                o_prdata = {28'h0, domain_cfg[2]};
                dcfg_wr[2] = 1'b1;
            end
            `SMM_DOMAIN_CFG0_OFS + 32'hC:
            begin
                o_prdata = {28'h0, domain_cfg[3]};
                dcfg_wr[3] = 1'b1;
            end
            `SMM_STANDBY_OFS:
                o_prdata = 32'h0000_0000;
            `SMM_STATUS_OFS:
                o_prdata = {30'h0, o_memory_clock_enable_out,
                    standby_ack_q};
            `SMM_CMD_WORD_OFS:
                o_prdata = {19'h0, last_cmd_word};
            default:
                apb_hit = 1'b0;
        endcase
        if (!(apb_access && i_pwrite))
            dcfg_wr = 4'h0;
    end
    assign o_pslverr = apb_access && !apb_hit;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            global_memory_config <= 3'(`SMM_GCFG_RESET);
        else if (apb_access && i_pwrite && i_paddr == `SMM_GLOBAL_CFG_OFS)
            global_memory_config <= i_pwdata[2:0];
    end

    // four domain registers, one device type each
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_dom
            smm_domain_cfg u_cfg
            (
                .i_core_clk(i_core_clk),
                .i_rstn(i_rstn),
                .i_wr(dcfg_wr[gi]),
                .i_wdata(i_pwdata),
                .o_cfg(domain_cfg[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // address decode and command word
    // ------------------------------------------------------------
    logic [1:0] req_domain;
    logic [3:0] cur_cfg;
    logic [12:0] cmd_word;
    logic standby_sync1;
    logic standby_sync2;
    logic standby_sync3;
    logic standby_level;

    // 256-Mbyte domains select on A29..A28
    assign req_domain = i_mem_addr[29:28];
    assign cur_cfg = domain_cfg[req_domain];

    smm_cmd_map u_map
    (
        .i_addr(i_mem_addr),
        .i_width16(cur_cfg[`SMM_DCFG_WIDTH16_BIT]),
        .o_word(cmd_word)
    );

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            standby_sync1 <= 1'b0;
            standby_sync2 <= 1'b0;
            standby_sync3 <= 1'b0;
            standby_level <= 1'b0;
        end
        else
        begin
            standby_sync1 <= i_standby_req;
            standby_sync2 <= standby_sync1;
            standby_sync3 <= standby_sync2;
            if (standby_sync2 == standby_sync3)
                standby_level <= standby_sync3;
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_ACCESS,
        ST_ENTER_PRE,
        ST_ENTER_NOP,
        ST_ENTER_CKE,
        ST_ENTER_REF,
        ST_SELF_REFRESH,
        ST_EXIT_STABLE,
        ST_EXIT_CKE,
        ST_EXIT_NOP,
        ST_EXIT_REF,
        ST_EXIT_DONE
    } smm_state_t;

    smm_state_t state;
    logic [7:0] wait_cnt;
    logic [7:0] refresh_cnt;
    logic [1:0] refresh_dom;
    logic refresh_due;
    logic refresh_skip;

    assign refresh_skip =
        domain_cfg[refresh_dom][`SMM_DCFG_SINGLE_WR_BIT];

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            refresh_cnt <= 8'h00;
            refresh_due <= 1'b0;
        end
        else if (state == ST_IDLE && refresh_due && !setup_active)
            refresh_due <= 1'b0;
        else if (refresh_cnt == `SMM_REFRESH_PERIOD_CYCLES)
        begin
            refresh_cnt <= 8'h00;
            refresh_due <= 1'b1;
        end
        else
            refresh_cnt <= refresh_cnt + 8'h01;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            state <= ST_IDLE;
            wait_cnt <= 8'h00;
            refresh_dom <= 2'h0;
            o_mem_cmd <= SMM_CMD_NOP;
            o_mem_addr <= 13'h0000;
            o_mem_dq_out <= 32'h0000_0000;
            o_mem_dq_oen <= 1'b1;
            o_mem_domain_sel <= 4'h0;
            o_mem_ack <= 1'b0;
            o_mem_rdata <= 32'h0000_0000;
            o_memory_clock_enable_out <= 1'b1;
            standby_ack_q <= 1'b0;
            last_cmd_word <= 13'h0000;
        end
        else
        begin
            o_mem_ack <= 1'b0;
            o_mem_dq_oen <= 1'b1;
            o_mem_cmd <= SMM_CMD_NOP;
            unique case (state)
                ST_IDLE:
                begin
                    o_mem_domain_sel <= 4'h0;
                    if (standby_level)
                    begin
                        state <= ST_ENTER_PRE;
                    end
                    else if (init_bit && !load_config_enable)
                    begin
                        o_mem_domain_sel <= 4'hF;
                        if (mode_set_enable)
                            o_mem_cmd <= SMM_CMD_NOP;
                        else
                            o_mem_cmd <= SMM_CMD_PRECHARGE_ALL;
                    end
                    else if (refresh_due && !setup_active)
                    begin
                        refresh_dom <= refresh_dom + 2'h1;
                        if (!refresh_skip)
                        begin
                            o_mem_cmd <= SMM_CMD_AUTO_REFRESH;
                            o_mem_domain_sel <= 4'(1 << refresh_dom);
                        end
                    end
                    else if (i_mem_req && !o_mem_ack)
                    begin
                        state <= ST_ACCESS;
                        o_mem_domain_sel <= 4'(1 << req_domain);
                        if (mode_set_enable && !i_mem_write)
                        begin
                            o_mem_cmd <= SMM_CMD_LOAD_MODE;
                            o_mem_addr <= cmd_word;
                            last_cmd_word <= cmd_word;
                            o_mem_rdata <= 32'h0000_0000;
                        end
                        else if (load_config_enable && !i_mem_write)
                        begin
                            o_mem_cmd <= SMM_CMD_FLASH_REG;
                            o_mem_addr <= cmd_word;
                            last_cmd_word <= cmd_word;
                            o_mem_dq_out <= i_mem_wdata;
                            o_mem_dq_oen <= 1'b0;
                            o_mem_rdata <= 32'h0000_0000;
                        end
                        else if (!setup_active)
                        begin
                            o_mem_addr <= cmd_word;
                            o_mem_cmd <= i_mem_write ? SMM_CMD_WRITE
                                : SMM_CMD_READ;
                            o_mem_dq_out <= i_mem_wdata;
                            o_mem_dq_oen <= !i_mem_write;
                        end
                        else
                        begin
                            // blocked: answered with zero data
                            o_mem_rdata <= 32'h0000_0000;
                        end
                    end
                end
                ST_ACCESS:
                begin
                    if (o_mem_cmd == SMM_CMD_READ)
                        o_mem_rdata <= i_mem_dq_in;
                    o_mem_ack <= 1'b1;
                    state <= ST_IDLE;
                end
                ST_ENTER_PRE:
                begin
                    o_mem_domain_sel <= 4'hF;
                    o_mem_cmd <= SMM_CMD_PRECHARGE_ALL;
                    state <= ST_ENTER_NOP;
                end
                ST_ENTER_NOP:
                    state <= ST_ENTER_CKE;
                ST_ENTER_CKE:
                begin
                    o_memory_clock_enable_out <= 1'b0;
                    state <= ST_ENTER_REF;
                end
                ST_ENTER_REF:
                begin
                    o_mem_cmd <= SMM_CMD_AUTO_REFRESH;
                    state <= ST_SELF_REFRESH;
                end
                ST_SELF_REFRESH:
                begin
                    o_mem_cmd <= SMM_CMD_SELF_REFRESH;
                    standby_ack_q <= 1'b1;
                    wait_cnt <= 8'h00;
                    if (!standby_level)
                        state <= ST_EXIT_STABLE;
                end
                ST_EXIT_STABLE:
                begin
                    // wake from self refresh before the core restarts
                    wait_cnt <= wait_cnt + 8'h01;
                    if (wait_cnt == 8'(`SMM_STABLE_CYCLES - 1))
                        state <= ST_EXIT_CKE;
                end
                ST_EXIT_CKE:
                begin
                    o_memory_clock_enable_out <= 1'b1;
                    wait_cnt <= 8'h00;
                    state <= ST_EXIT_NOP;
                end
                ST_EXIT_NOP:
                begin
                    wait_cnt <= wait_cnt + 8'h01;
                    if (wait_cnt == 8'(`SMM_WAKE_NOP_COUNT - 4'h1))
                        state <= ST_EXIT_REF;
                end
                ST_EXIT_REF:
                begin
                    o_mem_cmd <= SMM_CMD_AUTO_REFRESH;
                    state <= ST_EXIT_DONE;
                end
                ST_EXIT_DONE:
                begin
                    o_mem_cmd <= SMM_CMD_SELF_REFRESH_EXIT;
                    o_mem_domain_sel <= 4'h0;
                    standby_ack_q <= 1'b0;
                    state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
    assign o_standby_ack = standby_ack_q;
    // fields pass
    // through unchanged in the command word; software picks legal codes
endmodule

// [tb/smm_mem_model.sv]
// behavioural model of the memories on the far side
`timescale 1ns/100ps
module smm_mem_model
    import smm_pkg::*;
(
    input wire logic i_clk,
    input wire smm_cmd_t i_cmd,
    input wire logic [12:0] i_addr,
    input wire logic [3:0] i_sel,
    input wire logic [31:0] i_dq,
    input wire logic i_oen,
    input wire logic i_cke,
    output logic [31:0] o_dq
);
    logic [31:0] idle_dq = 32'h0;
    logic [12:0] word [4];
    logic [3:0] dom = 4'h0;
    logic [31:0] fdata = 32'h0;
    logic self_ref = 1'b0;
    int ar_cnt [4] = '{0, 0, 0, 0};
    int rw_cnt = 0;
    // ----
    // command decode
    // ----
    // idle data lines toggle so a stale value never looks valid
    // read data answers in the cycle the read command stands
    assign o_dq = i_cmd == SMM_CMD_READ
        ? {19'h0, i_addr} ^ 32'h5A5A_0000 : idle_dq;
    always @(posedge i_clk)
    begin
        idle_dq <= ~idle_dq;
        if (i_cmd == SMM_CMD_READ || i_cmd == SMM_CMD_WRITE)
            rw_cnt <= rw_cnt + 1;
        if (i_cmd == SMM_CMD_LOAD_MODE || i_cmd == SMM_CMD_FLASH_REG)
            dom <= i_sel;
        if (i_cmd == SMM_CMD_FLASH_REG && !i_oen)
            fdata <= i_dq;
        if (i_cmd == SMM_CMD_SELF_REFRESH)
            self_ref <= 1'b1;
        if (i_cmd == SMM_CMD_SELF_REFRESH_EXIT)
            self_ref <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            if (i_sel[k] && (i_cmd == SMM_CMD_LOAD_MODE
                || i_cmd == SMM_CMD_FLASH_REG))
                word[k] <= i_addr;
            if (i_sel[k] && i_cmd == SMM_CMD_AUTO_REFRESH && i_cke)
                ar_cnt[k] <= ar_cnt[k] + 1;
        end
    end
endmodule

// [tb/smm_top_monitor.sv]
// port checker for the mode setup block
`timescale 1ns/100ps
module smm_top_monitor
    import smm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_mem_req,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    input wire logic o_mem_ack,
    input wire logic [31:0] o_mem_rdata,
    input wire logic [12:0] o_mem_addr,
    input wire logic [31:0] o_mem_dq_out,
    input wire logic o_mem_dq_oen,
    input wire logic [3:0] o_mem_domain_sel,
    input wire smm_cmd_t o_mem_cmd,
    input wire logic o_memory_clock_enable_out
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    wire cke = o_memory_clock_enable_out;
    wire setup_cmd = o_mem_cmd == SMM_CMD_LOAD_MODE
        || o_mem_cmd == SMM_CMD_FLASH_REG;
    // ----
    // wake-up bookkeeping
    // ----
    // nops only count while the clock enable is high
    logic [4:0] nop_run;
    logic [4:0] ar_nops;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn || !cke || o_mem_cmd != SMM_CMD_NOP)
            nop_run <= 5'h00;
        else if (nop_run != 5'h1F)
            nop_run <= nop_run + 5'h01;
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            ar_nops <= 5'h00;
        else if (o_mem_cmd == SMM_CMD_AUTO_REFRESH)
            ar_nops <= nop_run;
    end
    sequence s_sleep_refresh;
        o_mem_cmd == SMM_CMD_AUTO_REFRESH && !cke;
    endsequence
    sequence s_enter_self;
        ##[1:4] o_mem_cmd == SMM_CMD_SELF_REFRESH;
    endsequence
    chk_mode_word:
    assert property (o_mem_cmd == SMM_CMD_LOAD_MODE |->
        o_mem_addr == i_mem_addr[22:10] || o_mem_addr == i_mem_addr[21:9])
    else $error("mode word not from read address");
    chk_setup_ack:
    assert property (setup_cmd |=> o_mem_ack && o_mem_rdata == 32'h0)
    else $error("setup read answer wrong");
    chk_ack_cause:
    assert property (o_mem_ack |-> $past(i_mem_req, 2) && !$past(o_mem_ack))
    else $error("ack without request");
    chk_flash_data:
    assert property (o_mem_cmd == SMM_CMD_FLASH_REG |->
        !o_mem_dq_oen && o_mem_dq_out == i_mem_wdata)
    else $error("flash command data wrong");
    chk_domain_sel:
    assert property (setup_cmd |->
        o_mem_domain_sel == 4'h1 << i_mem_addr[29:28])
    else $error("domain select wrong");
    chk_self_cke:
    assert property (o_mem_cmd == SMM_CMD_SELF_REFRESH |-> !cke)
    else $error("self refresh with clock enable high");
    chk_entry_order:
    assert property (s_sleep_refresh |-> s_enter_self)
    else $error("self refresh did not follow refresh");
    chk_exit_nops:
    assert property (o_mem_cmd == SMM_CMD_SELF_REFRESH_EXIT |->
        cke && ar_nops >= 5'h0A)
    else $error("too few nops before wake refresh");
endmodule
bind smm_top smm_top_monitor smm_top_monitor_i (.*);

// [tb/tb.sv]
// self-checking bench for the mode setup block
`timescale 1ns/100ps
module tb;
    import smm_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic mreq = 1'b0;
    logic mwr = 1'b0;
    logic sb = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] maddr = 32'h0;
    logic [31:0] mwdata = 32'h0;
    logic [31:0] prdata, rdata, dq_out, dq_in, rd_q, mrd_q, a, d;
    logic pready, pslverr, ack, sb_ack, oen, cke, err_q, w;
    logic [12:0] mad, wd;
    logic [3:0] dsel;
    smm_cmd_t cmd;
    int err_total = 0;
    int tests_run = 0;
    int hits, n0;
    int ar0 [4];
    // ----
    // setup read table: low address, domain config, burst nibble
    // ----
    logic [31:0] lo [6] = '{32'hC800, 32'h8C800, 32'h18400,
        32'h6600, 32'h46600, 32'hC400};
    logic [3:0] cfg [6] = '{4'h0, 4'hA, 4'h4, 4'h1, 4'hB, 4'h5};
    logic [3:0] nib [6] = '{4'h2, 4'h2, 4'h1, 4'h3, 4'h3, 4'h2};
    logic [3:0] hs [5] = '{4'h0, 4'hC, 4'hD, 4'hE, 4'hF};
    smm_top smm_top_i (
        .i_core_clk(clk),
        .i_rstn(rstn),
        .i_psel(psel),
        .i_penable(pen),
        .i_pwrite(pwr),
        .i_paddr(paddr),
        .i_pwdata(pwdata),
        .o_prdata(prdata),
        .o_pready(pready),
        .o_pslverr(pslverr),
        .i_mem_req(mreq),
        .i_mem_write(mwr),
        .i_mem_addr(maddr),
        .i_mem_wdata(mwdata),
        .o_mem_ack(ack),
        .o_mem_rdata(rdata),
        .i_mem_dq_in(dq_in),
        .i_standby_req(sb),
        .o_standby_ack(sb_ack),
        .o_mem_addr(mad),
        .o_mem_dq_out(dq_out),
        .o_mem_dq_oen(oen),
        .o_mem_domain_sel(dsel),
        .o_mem_cmd(cmd),
        .o_memory_clock_enable_out(cke)
    );
    smm_mem_model smm_mem_model_i (
        .i_clk(clk),
        .i_cmd(cmd),
        .i_addr(mad),
        .i_sel(dsel),
        .i_dq(dq_out),
        .i_oen(oen),
        .i_cke(cke),
        .o_dq(dq_in)
    );
    always #25 clk = ~clk;
    function automatic logic [12:0] exp_word(input logic [31:0] x,
        input logic h);
        return h ? x[21:9] : x[22:10];
    endfunction
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
        tests_run++;
        if (got !== e)
        begin
            err_total++;
            $display("FAIL %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic e);
        cmp_word({31'h0, got}, {31'h0, e});
    endtask
    task automatic apb(input logic wr, input logic [31:0] ad,
        input logic [31:0] dt);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= ad;
        pwdata <= dt;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            err_total++;
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // the request stays up until ack is seen, or is released after 400 cycles without ack
    task automatic mem(input logic wr, input logic [31:0] ad,
        input logic [31:0] dt);
        int n;
        @(posedge clk);
        mreq <= 1'b1;
        mwr <= wr;
        maddr <= ad;
        mwdata <= dt;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 400);
        if (ack !== 1'b1)
            err_total++;
        mrd_q = rdata;
        mreq <= 1'b0;
    endtask
    task automatic count(input smm_cmd_t c, input int n);
        hits = 0;
        repeat (n)
        begin
            @(posedge clk);
            if (cmd === c)
                hits++;
        end
    endtask
    task automatic wait_sb(input logic lv);
        int n;
        n = 0;
        while (sb_ack !== lv && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        if (sb_ack !== lv)
            err_total++;
        // the model latches the last sleep command one edge later
        @(posedge clk);
    endtask
    task automatic give_verdict;
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(43));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, 32'h0, 32'h0);
        cmp_word(rd_q, 32'h1);
        apb(1'b0, 32'h3C, 32'h0);
        cmp_word({rd_q[30:0], err_q}, 32'h1);
        count(SMM_CMD_PRECHARGE_ALL, 6);
        cmp_flag(hits > 0, 1'b1);
        apb(1'b1, 32'h0, 32'h3);
        repeat (2) @(posedge clk);
        count(SMM_CMD_NOP, 8);
        cmp_word(hits, 32'h8);
        apb(1'b1, 32'h0, 32'h2);
        for (int i = 0; i < 12; i++)
        begin
            a = $urandom;
            if (i < 6)
                a = {hs[$urandom_range(4)], 28'h0} | lo[i];
            w = i < 6 && cfg[i][0];
            apb(1'b1, 32'h10 + {a[29:28], 2'h0}, i < 6 ? cfg[i] : 4'h0);
            mem(1'b0, a, 32'h0);
            wd = smm_mem_model_i.word[a[29:28]];
            cmp_word(wd, exp_word(a, w));
            cmp_word(mrd_q, 32'h0);
            cmp_word(smm_mem_model_i.dom, 4'h1 << a[29:28]);
            if (i < 6)
            begin
                cmp_word(wd[3:0], nib[i]);
                cmp_word({wd[12:10], wd[8:7]}, 32'h0);
                cmp_flag(wd[9], cfg[i][1]);
                if (cfg[i][3:2] != 2'h1)
                    cmp_word(wd[6:4], 3'h3);
            end
        end
        n0 = smm_mem_model_i.rw_cnt;
        mem(1'b1, 32'hC000_0100, $urandom);
        cmp_word(smm_mem_model_i.rw_cnt, n0);
        repeat (2000) @(posedge clk);
        apb(1'b1, 32'h0, 32'h4);
        apb(1'b1, 32'h10, 32'hA);
        a = 32'hC000_0000 | ($urandom & 32'h03FF_FFFF);
        d = $urandom;
        mem(1'b0, a, d);
        cmp_word(smm_mem_model_i.fdata, d);
        cmp_word(smm_mem_model_i.word[0], a[22:10]);
        apb(1'b1, 32'h0, 32'h0);
        for (int i = 0; i < 4; i++)
            apb(1'b1, 32'h10 + 4 * i, i == 1 ? 32'h2 : 32'h0);
        n0 = smm_mem_model_i.rw_cnt;
        mem(1'b1, 32'hC000_0040, $urandom);
        cmp_word(smm_mem_model_i.rw_cnt, n0 + 1);
        a = 32'hC000_0000 | ($urandom & 32'h03FF_FFFF);
        mem(1'b0, a, 32'h0);
        cmp_word(mrd_q, {19'h0, exp_word(a, 1'b0)} ^ 32'h5A5A_0000);
        ar0 = smm_mem_model_i.ar_cnt;
        repeat (1300) @(posedge clk);
        for (int i = 0; i < 4; i++)
            cmp_flag(smm_mem_model_i.ar_cnt[i] > ar0[i], i != 1);
        sb <= 1'b1;
        wait_sb(1'b1);
        cmp_flag(cke, 1'b0);
        cmp_flag(smm_mem_model_i.self_ref, 1'b1);
        apb(1'b0, 32'h24, 32'h0);
        cmp_word(rd_q, 32'h1);
        sb <= 1'b0;
        wait_sb(1'b0);
        cmp_flag(cke, 1'b1);
        cmp_flag(smm_mem_model_i.self_ref, 1'b0);
        give_verdict;
    end
endmodule
